// ==== logic/mdau_top.sv ====
// Overview of operation
// - Unsigned accumulate sets overflow when the sum leaves the 32-bit range
// - Signed accumulate sets overflow when like-signed addends give opposite sign
// - Unsigned accumulate keeps the sign flag at zero
// - Signed accumulate copies bit 31 of the sum into the sign flag
// - Start bit can only be set when division mode is selected
// - Writing start in division mode begins division; bit reads one while busy
// - Hardware clears the start bit when the division finishes
// - Multiply modes start automatically on a write of the upper operand A
// - Software writing zero to start during division is ignored
// - Sign and overflow flags are read only
// - Negative upper accumulator written in signed accumulate sets sign at once
// - Product lands in register B two clocks after the trigger
// - Accumulate ends one clock after the product; software waits two clocks
// - Non-negative signed accumulate result clears the sign flag
// - Accumulate overflow sets overflow flag and raises the done interrupt
// - Mode and lower operand A are kept between multiply and accumulate operations
// - Signed accumulate treats operands, product and sum as two's complement
// - Mode bits decode to multiply, accumulate and two division variants
// - Division takes dividend from A and writes quotient back to A
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mdau_top (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [mdau_pkg::ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [mdau_pkg::BUS_W-1:0] pwdata, // APB write data
	output logic [mdau_pkg::BUS_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic arithDoneIrq // Completion interrupt pulse
);
	import mdau_pkg::*;

	logic divSel_r;
	logic accSel_r;
	logic sgnSel_r;
	logic accumOverflowFlag_r;
	logic accumSignFlag_r;
	logic divBusy_r;
	logic [HALF_W-1:0] opALo_r;
	logic [HALF_W-1:0] opAHi_r;
	logic [HALF_W-1:0] prodLo_r;
	logic [HALF_W-1:0] prodHi_r;
	logic [HALF_W-1:0] accLo_r;
	logic [HALF_W-1:0] accHi_r;
	logic mulGo_r;
	logic accGo_r;
	logic divKick_r;
	logic irq_r;
	logic [BUS_W-1:0] prdata_r;
	logic [BUS_W-1:0] prdata_nxt;
	logic [BUS_W-1:0] product_nxt;
	logic [BUS_W:0] accumSum_nxt;
	logic [BUS_W-1:0] bAll;
	logic [BUS_W-1:0] cAll;
	logic [2:0] modeNow;
	logic [2:0] modeWr;
	logic ovfNow;
	logic access;
	logic addrOk;
	logic wrEn;
	logic wrCtrl;
	logic wrALo;
	logic wrAHi;
	logic wrBLo;
	logic wrBHi;
	logic wrCLo;
	logic wrCHi;

	mdau_div_if #(.W(DIV_W)) divLink ();

	mdau_divider #(.W(DIV_W)) u_divider (
		.clk_sys(clk_sys),
		.rst(rst),
		.dv(divLink.engine)
	);

	function automatic logic isAcc(input logic [2:0] m);
		return (m == MD_MACU) || (m == MD_MACS);
	endfunction : isAcc

	function automatic logic isDiv(input logic [2:0] m);
		return (m == MD_DIVI) || (m == MD_DIVN);
	endfunction : isDiv

	function automatic logic isMul(input logic [2:0] m);
		return (m == MD_MULU) || (m == MD_MULS);
	endfunction : isMul

	function automatic logic regHit(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CTRL, ADDR_A_LO, ADDR_A_HI: return 1'b1;
			ADDR_B_LO, ADDR_B_HI: return 1'b1;
			ADDR_C_LO, ADDR_C_HI: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : regHit

	// Two's complement low word equals the signed product
	function automatic logic [BUS_W-1:0] mul32(input logic [HALF_W-1:0] a,
		input logic [HALF_W-1:0] b, input logic s);
		logic [BUS_W-1:0] ea;
		logic [BUS_W-1:0] eb;
		ea = s ? {{HALF_W{a[HALF_W-1]}}, a} : {{HALF_W{1'b0}}, a};
		eb = s ? {{HALF_W{b[HALF_W-1]}}, b} : {{HALF_W{1'b0}}, b};
		return BUS_W'(ea * eb);
	endfunction : mul32

	// APB decode
	assign access = psel & penable;
	assign addrOk = regHit(paddr);
	assign wrEn = access & pwrite & addrOk;
	assign wrCtrl = wrEn && (paddr == ADDR_CTRL);
	assign wrALo = wrEn && (paddr == ADDR_A_LO);
	assign wrAHi = wrEn && (paddr == ADDR_A_HI);
	assign wrBLo = wrEn && (paddr == ADDR_B_LO);
	assign wrBHi = wrEn && (paddr == ADDR_B_HI);
	assign wrCLo = wrEn && (paddr == ADDR_C_LO);
	assign wrCHi = wrEn && (paddr == ADDR_C_HI);
	assign pready = access;
	assign pslverr = access & ~addrOk;
	assign prdata = prdata_r;
	assign arithDoneIrq = irq_r;

	assign modeNow = {divSel_r, accSel_r, sgnSel_r};
	assign modeWr = {pwdata[CB_DIV], pwdata[CB_ACC], pwdata[CB_SGN]};
	assign bAll = {prodHi_r, prodLo_r};
	assign cAll = {accHi_r, accLo_r};

	// Datapath
	assign product_nxt = mul32(opAHi_r, opALo_r, sgnSel_r);
	assign accumSum_nxt = {1'b0, cAll} + {1'b0, bAll};
	always_comb begin
		if (modeNow == MD_MACS) begin
			ovfNow = (bAll[BUS_W-1] == cAll[BUS_W-1]) &&
				(accumSum_nxt[BUS_W-1] != cAll[BUS_W-1]);
		end else begin
			ovfNow = accumSum_nxt[BUS_W];
		end
	end

	// Mode bits survive between operations
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divSel_r <= CTRL_BIT_RST;
			accSel_r <= CTRL_BIT_RST;
			sgnSel_r <= CTRL_BIT_RST;
		end else if (wrCtrl) begin
			divSel_r <= pwdata[CB_DIV];
			accSel_r <= pwdata[CB_ACC];
			sgnSel_r <= pwdata[CB_SGN];
		end
	end

	// Division start and busy bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divBusy_r <= CTRL_BIT_RST;
			divKick_r <= 1'b0;
		end else begin
			divKick_r <= 1'b0;
			if (divLink.done) begin
				divBusy_r <= 1'b0;
			end else if (wrCtrl && pwdata[CB_START] && isDiv(modeWr) && !divBusy_r) begin
				divBusy_r <= 1'b1;
				divKick_r <= 1'b1;
			end
		end
	end

	assign divLink.start = divKick_r;
	assign divLink.dividend = {opAHi_r, opALo_r};
	assign divLink.divisor = bAll;

	// Multiply and accumulate pipeline
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mulGo_r <= 1'b0;
			accGo_r <= 1'b0;
		end else begin
			mulGo_r <= wrAHi && !isDiv(modeNow);
			accGo_r <= mulGo_r && isAcc(modeNow);
		end
	end

	// Operand A, quotient returns here
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			opALo_r <= HALF_RST;
			opAHi_r <= HALF_RST;
		end else if (divLink.done) begin
			{opAHi_r, opALo_r} <= divLink.quotient;
		end else begin
			if (wrALo) begin
				opALo_r <= pwdata[HALF_W-1:0];
			end
			if (wrAHi) begin
				opAHi_r <= pwdata[HALF_W-1:0];
			end
		end
	end

	// Product register B
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prodLo_r <= HALF_RST;
			prodHi_r <= HALF_RST;
		end else if (mulGo_r) begin
			{prodHi_r, prodLo_r} <= product_nxt;
		end else begin
			if (wrBLo) begin
				prodLo_r <= pwdata[HALF_W-1:0];
			end
			if (wrBHi) begin
				prodHi_r <= pwdata[HALF_W-1:0];
			end
		end
	end

	// Accumulator C, remainder returns here
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accLo_r <= HALF_RST;
			accHi_r <= HALF_RST;
		end else if (accGo_r) begin
			{accHi_r, accLo_r} <= accumSum_nxt[BUS_W-1:0];
		end else if (divLink.done) begin
			{accHi_r, accLo_r} <= divLink.remainder;
		end else begin
			if (wrCLo) begin
				accLo_r <= pwdata[HALF_W-1:0];
			end
			if (wrCHi) begin
				accHi_r <= pwdata[HALF_W-1:0];
			end
		end
	end

	// Status flags, not written through the control register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accumOverflowFlag_r <= CTRL_BIT_RST;
		end else if (accGo_r) begin
			accumOverflowFlag_r <= ovfNow;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			accumSignFlag_r <= CTRL_BIT_RST;
		end else if (modeNow != MD_MACS) begin
			accumSignFlag_r <= 1'b0;
		end else if (accGo_r) begin
			accumSignFlag_r <= accumSum_nxt[BUS_W-1];
		end else if (wrCHi) begin
			accumSignFlag_r <= pwdata[HALF_W-1];
		end
	end

	// Completion interrupt pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (accGo_r && ovfNow) ||
				(divLink.done && modeNow == MD_DIVI);
		end
	end

	// Read data captured in the setup phase
	always_comb begin
		prdata_nxt = BUS_ZERO;
		case (paddr)
			ADDR_CTRL: begin
				prdata_nxt[CB_DIV] = divSel_r;
				prdata_nxt[CB_ACC] = accSel_r;
				prdata_nxt[CB_SGN] = sgnSel_r;
				prdata_nxt[CB_OVF] = accumOverflowFlag_r;
				prdata_nxt[CB_SIGN] = accumSignFlag_r;
				prdata_nxt[CB_START] = divBusy_r;
			end
			ADDR_A_LO: prdata_nxt[HALF_W-1:0] = opALo_r;
			ADDR_A_HI: prdata_nxt[HALF_W-1:0] = opAHi_r;
			ADDR_B_LO: prdata_nxt[HALF_W-1:0] = prodLo_r;
			ADDR_B_HI: prdata_nxt[HALF_W-1:0] = prodHi_r;
			ADDR_C_LO: prdata_nxt[HALF_W-1:0] = accLo_r;
			ADDR_C_HI: prdata_nxt[HALF_W-1:0] = accHi_r;
			default: prdata_nxt = BUS_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdata_r <= BUS_ZERO;
		end else if (psel && !penable) begin
			prdata_r <= prdata_nxt;
		end
	end

	// Checks
	default clocking dcb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_mul_latency: assert property (
		(wrAHi && isMul(modeNow)) |-> ##2 ($past(sgnSel_r) ?
		($signed(bAll) == $signed($past(opAHi_r)) * $signed($past(opALo_r))) :
		(bAll == $past(opAHi_r) * $past(opALo_r))))
		else $error("product not in B two cycles after trigger");
	a_acc_sum: assert property (
		(mulGo_r && isAcc(modeNow) && !wrCLo && !wrCHi) ##1 (!wrCLo && !wrCHi)
		|=> (cAll == BUS_W'($past(cAll, 2) + $past(bAll))))
		else $error("accumulator not updated with product");
	a_unsigned_ovf: assert property (
		(accGo_r && modeNow == MD_MACU) |=> (accumOverflowFlag_r == ($past(cAll) > ~$past(bAll))))
		else $error("unsigned overflow flag wrong");
	a_signed_sign: assert property (
		(accGo_r && modeNow == MD_MACS && !wrCtrl) |=> (accumSignFlag_r == accHi_r[HALF_W-1]))
		else $error("sign flag does not follow accumulator");
	a_unsigned_sign: assert property (
		(modeNow == MD_MACU && $past(modeNow) == MD_MACU) |-> !accumSignFlag_r)
		else $error("sign flag set in unsigned accumulate");
	a_sign_preset: assert property (
		(wrCHi && pwdata[HALF_W-1] && modeNow == MD_MACS && !accGo_r) |=> accumSignFlag_r)
		else $error("negative preset did not set sign flag");
	a_ovf_irq: assert property (
		(accGo_r && ovfNow) |=> (accumOverflowFlag_r && arithDoneIrq))
		else $error("overflow did not raise flag and interrupt");

	a_start_mode: assert property (
		(wrCtrl && pwdata[CB_START] && !isDiv(modeWr) && !divBusy_r) |=> !divBusy_r)
		else $error("start bit set outside division mode");

	a_start_busy: assert property (
		(wrCtrl && pwdata[CB_START] && isDiv(modeWr) && !divBusy_r) |=> divBusy_r [*8])
		else $error("start bit not held during division");

	a_start_hold: assert property (
		(divBusy_r && !divLink.done) |=> divBusy_r)
		else $error("start bit dropped before division end");

	a_div_end: assert property (
		divLink.done |=> (!divBusy_r && {opAHi_r, opALo_r} == $past(divLink.quotient)))
		else $error("division end did not clear start or store quotient");

	a_div_irq: assert property (
		(divLink.done && modeNow == MD_DIVI) |=> arithDoneIrq ##1 !arithDoneIrq)
		else $error("division interrupt not a single pulse");

	a_ro_flags: assert property (
		(wrCtrl && !accGo_r) |=> $stable(accumOverflowFlag_r))
		else $error("software write changed overflow flag");

	c_signed_mac: cover property (accGo_r && modeNow == MD_MACS);
	c_mac_ovf: cover property (accGo_r && ovfNow);
	c_div_irq: cover property (divLink.done && modeNow == MD_DIVI);
	c_bad_addr: cover property (pslverr);
endmodule : mdau_top
`default_nettype wire

// ==== logic/mdau_pkg.sv ====
package mdau_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int BUS_W = 32;
	localparam int HALF_W = 16;
	localparam int DIV_W = 32;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_A_LO = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_A_HI = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_B_LO = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_B_HI = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_C_LO = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_C_HI = 8'h18;

	// Control register field positions
	localparam int CB_DIV = 7;
	localparam int CB_ACC = 6;
	localparam int CB_SGN = 3;
	localparam int CB_OVF = 2;
	localparam int CB_SIGN = 1;
	localparam int CB_START = 0;

	// Reset values
	localparam logic CTRL_BIT_RST = 1'b0;
	localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
	localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;

	// Mode codes, {division, accumulate, signed}
	localparam logic [2:0] MD_MULU = 3'h0;
	localparam logic [2:0] MD_MULS = 3'h1;
	localparam logic [2:0] MD_MACU = 3'h2;
	localparam logic [2:0] MD_MACS = 3'h3;
	localparam logic [2:0] MD_DIVI = 3'h4;
	localparam logic [2:0] MD_DIVN = 3'h6;
endpackage : mdau_pkg

// ==== logic/mdau_div_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface mdau_div_if #(parameter int W = mdau_pkg::DIV_W);
	logic start;
	logic [W-1:0] dividend;
	logic [W-1:0] divisor;
	logic done;
	logic [W-1:0] quotient;
	logic [W-1:0] remainder;
	modport ctl (output start, output dividend, output divisor,
		input done, input quotient, input remainder);
	modport engine (input start, input dividend, input divisor,
		output done, output quotient, output remainder);
endinterface : mdau_div_if
`default_nettype wire

// ==== logic/mdau_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
module mdau_divider #(
	parameter int W = mdau_pkg::DIV_W
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	mdau_div_if.engine dv // Operands and result
);
	import mdau_pkg::*;

	localparam int CW = $clog2(W) + 1;
	localparam int DIV_LAT_MAX = W + 2;
	localparam logic [CW-1:0] STEP_ONE = CW'(1);
	localparam logic [CW-1:0] STEPS = CW'(W);

	typedef enum logic [1:0] {
		DS_IDLE = 2'b01,
		DS_RUN = 2'b10
	} mdau_dstate_t;

	mdau_dstate_t state_r;
	logic [W-1:0] quo_r;
	logic [W-1:0] rem_r;
	logic [W-1:0] dvs_r;
	logic [CW-1:0] cnt_r;
	logic done_r;
	logic [W:0] trial;
	logic [W:0] diff;

	// Restoring division, one quotient bit per clock
	assign trial = {rem_r, quo_r[W-1]};
	assign diff = trial - {1'b0, dvs_r};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= DS_IDLE;
			quo_r <= '0;
			rem_r <= '0;
			dvs_r <= '0;
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				DS_IDLE: begin
					if (dv.start) begin
						quo_r <= dv.dividend;
						rem_r <= '0;
						dvs_r <= dv.divisor;
						cnt_r <= STEPS;
						state_r <= DS_RUN;
					end
				end
				DS_RUN: begin
					if (!diff[W]) begin
						rem_r <= diff[W-1:0];
						quo_r <= {quo_r[W-2:0], 1'b1};
					end else begin
						rem_r <= trial[W-1:0];
						quo_r <= {quo_r[W-2:0], 1'b0};
					end
					cnt_r <= cnt_r - STEP_ONE;
					if (cnt_r == STEP_ONE) begin
						done_r <= 1'b1;
						state_r <= DS_IDLE;
					end
				end
				default: state_r <= DS_IDLE;
			endcase
		end
	end

	assign dv.done = done_r;
	assign dv.quotient = quo_r;
	assign dv.remainder = rem_r;

	a_div_length: assert property (@(posedge clk_sys) disable iff (rst)
		(dv.start && state_r == DS_IDLE) |-> ##[2:DIV_LAT_MAX] dv.done)
		else $error("division did not finish in time");
endmodule : mdau_divider
`default_nettype wire

// ==== bench/mdau_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
	import mdau_pkg::*;
	typedef struct {
		logic [2:0] mode;
		logic [31:0] cInit;
		logic [15:0] aLo;
		logic [15:0] aHi;
		logic [31:0] expB;
		logic [31:0] expC;
		logic [1:0] expFlags; // {overflow, sign}
	} mdau_case_t;
	logic clkSys, rst, psel, penable, pwrite, pready, pslverr, arithDoneIrq, err;
	logic [ADDR_W-1:0] paddr;
	logic [BUS_W-1:0] pwdata, prdata, v;
	int errors, n_checks, irqCount, cycles, irqBefore, n;
	mdau_case_t cases [8];
	logic [7:0] wrVal [4];
	logic [7:0] rdExp [4];

	mdau_top u_mdau_top (
		.clk_sys(clkSys),
		.rst(rst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.arithDoneIrq(arithDoneIrq)
	);

	initial begin
		clkSys = 1'b0;
		forever #4 clkSys = ~clkSys;
	end

	always @(posedge clkSys) begin
		if (arithDoneIrq === 1'b1) irqCount++;
		cycles++;
		if (cycles == 5000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
		input logic [BUS_W-1:0] data, output logic [BUS_W-1:0] rdata, output logic slvErr);
		int k;
		k = 0;
		@(posedge clkSys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clkSys);
		penable <= 1'b1;
		do begin
			@(posedge clkSys);
			k++;
		end while (pready !== 1'b1);
		rdata = prdata;
		slvErr = pslverr;
		chk("wait states", 1, k);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] addr, input logic [BUS_W-1:0] data);
		apb(1'b1, addr, data, v, err);
	endtask : wr

	task automatic rdChk(input string name, input logic [ADDR_W-1:0] addr,
		input logic [BUS_W-1:0] exp);
		apb(1'b0, addr, 32'h0, v, err);
		chk(name, exp, v);
	endtask : rdChk

	function automatic logic [7:0] mctl(input logic [2:0] m);
		return {m[2], m[1], 2'b00, m[0], 3'b000};
	endfunction : mctl

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rst = 1'b1;
		errors = 0;
		n_checks = 0;
		irqCount = 0;
		cycles = 0;
		cases = '{
			'{MD_MULU, 32'h0, 16'hffff, 16'hffff, 32'hfffe0001, 32'h0, 2'b00},
			'{MD_MULS, 32'h0, 16'hffff, 16'h0002, 32'hfffffffe, 32'h0, 2'b00},
			'{MD_MACU, 32'hfffffff0, 16'h0004, 16'h0005, 32'h14, 32'h4, 2'b10},
			'{MD_MACU, 32'h100, 16'h0003, 16'h0004, 32'hc, 32'h10c, 2'b00},
			'{MD_MACS, 32'h7ffffff0, 16'h0100, 16'h0100, 32'h10000, 32'h8000fff0, 2'b11},
			'{MD_MACS, 32'h80000000, 16'hffff, 16'h0001, 32'hffffffff, 32'h7fffffff, 2'b10},
			'{MD_MACS, 32'hfffffff0, 16'h0002, 16'h0003, 32'h6, 32'hfffffff6, 2'b01},
			'{MD_MACS, 32'hfffffff0, 16'h0010, 16'h0001, 32'h10, 32'h0, 2'b00}};
		wrVal = '{8'h06, 8'h01, 8'h09, 8'h41};
		rdExp = '{8'h00, 8'h00, 8'h08, 8'h40};
		repeat (8) @(posedge clkSys);
		rst <= 1'b0;
		rdChk("control reset", ADDR_CTRL, 32'h0);
		rdChk("operand_a_lower reset", ADDR_A_LO, 32'h0);
		rdChk("accumulator_upper reset", ADDR_C_HI, 32'h0);
		foreach (cases[i]) begin
			irqBefore = irqCount;
			wr(ADDR_CTRL, {24'h0, mctl(cases[i].mode)});
			if (cases[i].mode[1]) begin
				wr(ADDR_C_HI, {16'h0, cases[i].cInit[31:16]});
				wr(ADDR_C_LO, {16'h0, cases[i].cInit[15:0]});
			end
			wr(ADDR_A_LO, {16'h0, cases[i].aLo});
			wr(ADDR_A_HI, {16'h0, cases[i].aHi});
			rdChk("product_lower", ADDR_B_LO, {16'h0, cases[i].expB[15:0]});
			rdChk("product_upper", ADDR_B_HI, {16'h0, cases[i].expB[31:16]});
			if (cases[i].mode[1]) begin
				rdChk("accumulator_lower", ADDR_C_LO, {16'h0, cases[i].expC[15:0]});
				rdChk("accumulator_upper", ADDR_C_HI, {16'h0, cases[i].expC[31:16]});
				rdChk("flags", ADDR_CTRL,
					{24'h0, mctl(cases[i].mode) | {5'h0, cases[i].expFlags, 1'b0}});
				chk("irq pulses", irqBefore + cases[i].expFlags[1], irqCount);
			end
		end
		// Read-only flags and start bit outside division
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CTRL, {24'h0, wrVal[k]});
			rdChk("control", ADDR_CTRL, {24'h0, rdExp[k]});
		end
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_A_LO, 32'h7);
		wr(ADDR_A_HI, 32'h3);
		rdChk("product_lower", ADDR_B_LO, 32'd21);
		wr(ADDR_A_HI, 32'h5);
		rdChk("product_lower", ADDR_B_LO, 32'd35);
		wr(ADDR_CTRL, 32'h48);
		wr(ADDR_C_HI, 32'h8000);
		rdChk("sign at once", ADDR_CTRL, 32'h4a);
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, k ? 32'hc0 : 32'h80);
			wr(ADDR_A_HI, 32'h1);
			wr(ADDR_A_LO, 32'h5);
			wr(ADDR_B_LO, 32'h10);
			wr(ADDR_B_HI, 32'h0);
			irqBefore = irqCount;
			wr(ADDR_CTRL, k ? 32'hc1 : 32'h81);
			rdChk("busy", ADDR_CTRL, k ? 32'hc1 : 32'h81);
			wr(ADDR_CTRL, k ? 32'hc0 : 32'h80);
			rdChk("busy held", ADDR_CTRL, k ? 32'hc1 : 32'h81);
			n = 0;
			do begin
				apb(1'b0, ADDR_CTRL, 32'h0, v, err);
				n++;
			end while (v[0] === 1'b1 && n < 100);
			chk("busy cleared", 32'h0, {31'h0, v[0]});
			rdChk("quotient lower", ADDR_A_LO, 32'h1000);
			rdChk("quotient upper", ADDR_A_HI, 32'h0);
			rdChk("remainder", ADDR_C_LO, 32'h5);
			chk("division irq", irqBefore + (k ? 0 : 1), irqCount);
		end
		// Reset in mid-run clears operands and accumulator
		rst <= 1'b1;
		repeat (2) @(posedge clkSys);
		rst <= 1'b0;
		rdChk("operand_a_lower mid reset", ADDR_A_LO, 32'h0);
		rdChk("accumulator_lower mid reset", ADDR_C_LO, 32'h0);
		rdChk("control mid reset", ADDR_CTRL, 32'h0);
		apb(1'b0, 8'h1c, 32'h0, v, err);
		chk("slave error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, v);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
